// *** include/flh_pkg.sv ***
// Shared constants and types for the FCoE aggregated-link selector.
`default_nettype none
package flh_pkg;
    localparam int SID_W = 24;
    localparam int DID_W = 24;
    localparam int FABID_W = 12;
    localparam int PORT_W = 8;
    localparam int MOD_W = 8;
    localparam int OXID_W = 16;
    localparam int HASH_W = 16;
    localparam int LINK_W = 4;
    localparam int TAG_W = 16;
    localparam int FIFO_DEPTH = 32;
    localparam int FIFO_AW = 5;
    localparam logic [HASH_W-1:0] HASH_SEED = 16'hFFFF;
    localparam logic [HASH_W-1:0] HASH_POLY = 16'h1021;
    localparam logic OXID_EN_RESET = 1'b1;
    localparam int KEY_W = SID_W + DID_W + FABID_W + PORT_W + MOD_W + OXID_W;
    localparam int ENTRY_W = TAG_W + 1 + KEY_W;
    typedef enum logic [1:0] {FLH_IDLE, FLH_HASH, FLH_MOD, FLH_OUT} flh_state_e;
endpackage
`default_nettype wire

// *** hw/flh_fifo.sv ***
// Parameterised first-in first-out buffer with valid and ready on both sides.
`timescale 1ns/1ps
`default_nettype none
module flh_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 32,
    parameter int AW = 5
) (
    input wire logic mclk,
    input wire logic rst,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wr_reg, wr_next, rd_reg, rd_next;
    logic [AW:0] cnt_reg, cnt_next;
    logic [WIDTH-1:0] dout_reg, dout_next;
    logic dv_reg, dv_next;
    logic push, pop, load;

    // Read data sit in a register; the output stage is one slot beyond the DEPTH memory entries.
    always_comb
    begin
        push = in_valid && in_ready;
        load = (cnt_reg != '0) && (!dv_reg || out_ready);
        pop = dv_reg && out_ready;
        wr_next = push ? wr_reg + 1'b1 : wr_reg;
        rd_next = load ? rd_reg + 1'b1 : rd_reg;
        cnt_next = cnt_reg + {{AW{1'b0}}, push} - {{AW{1'b0}}, load};
        dout_next = load ? mem[rd_reg] : dout_reg;
        dv_next = load ? 1'b1 : (pop ? 1'b0 : dv_reg);
    end

    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            wr_reg <= '0;
            rd_reg <= '0;
            cnt_reg <= '0;
            dv_reg <= 1'b0;
            dout_reg <= '0;
        end
        else
        begin
            wr_reg <= wr_next;
            rd_reg <= rd_next;
            cnt_reg <= cnt_next;
            dv_reg <= dv_next;
            dout_reg <= dout_next;
        end
    end

    always_ff @(posedge mclk)
    begin
        if (push)
        begin
            mem[wr_reg] <= in_data;
        end
    end

    assign in_ready = (cnt_reg != DEPTH[AW:0]);
    assign out_valid = dv_reg;
    assign out_data = dout_reg;
endmodule
`default_nettype wire

// *** hw/flh_select.sv ***
// Hash-based member-link selector for FCoE frames leaving on an aggregated group.
// How it works
// - Hash always covers the five fixed fields.
// - Hash picks one member link, or drops the frame when its group has no active links.
// - Exchange identifier included after reset.
// - Cleared setting drops exchange identifier from hash.
// - Separate fabric and Ethernet settings, group-wide.
// - Fabric ports always hashed as one group.
// - Excluded identifier keeps endpoint pairs on one link.
// - Selection applies to forwarder-facing aggregated traffic.
// - Included identifier spreads exchanges over links.
`timescale 1ns/1ps
`default_nettype none
module flh_select (
    input wire logic mclk,
    input wire logic rst,
    input wire logic oxid_en_fabric,
    input wire logic oxid_en_ethernet,
    input wire logic [flh_pkg::LINK_W:0] fabric_active_count,
    input wire logic [flh_pkg::LINK_W:0] ethernet_active_count,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [flh_pkg::TAG_W-1:0] in_tag,
    input wire logic in_is_fabric,
    input wire logic [flh_pkg::SID_W-1:0] in_source_id,
    input wire logic [flh_pkg::DID_W-1:0] in_destination_id,
    input wire logic [flh_pkg::FABID_W-1:0] in_fabric_identifier,
    input wire logic [flh_pkg::PORT_W-1:0] in_ingress_port_number,
    input wire logic [flh_pkg::MOD_W-1:0] in_ingress_module_number,
    input wire logic [flh_pkg::OXID_W-1:0] in_exchange_id,
    output logic out_valid,
    input wire logic out_ready,
    output logic [flh_pkg::TAG_W-1:0] out_tag,
    output logic [flh_pkg::LINK_W-1:0] out_link,
    output logic [flh_pkg::HASH_W-1:0] out_hash,
    output logic out_drop
);
    localparam int KW = flh_pkg::KEY_W;
    localparam int EW = flh_pkg::ENTRY_W;
    localparam int HW = flh_pkg::HASH_W;
    localparam int LW = flh_pkg::LINK_W;

    // Bitwise CRC over the key; pure function so equal keys give equal hashes.
    function automatic logic [HW-1:0] key_hash(input logic [KW-1:0] key);
        logic [HW-1:0] h;
        logic fb;
        h = flh_pkg::HASH_SEED;
        for (int i = KW - 1; i >= 0; i--)
        begin
            fb = h[HW-1] ^ key[i];
            h = {h[HW-2:0], 1'b0} ^ (fb ? flh_pkg::HASH_POLY : '0);
        end
        return h;
    endfunction

    // The group bit sits just below the tag in a queued entry.
    function automatic logic entry_is_fabric(input logic [EW-1:0] entry);
        return entry[EW-flh_pkg::TAG_W-1];
    endfunction

    function automatic logic [flh_pkg::TAG_W-1:0] entry_tag(input logic [EW-1:0] entry);
        return entry[EW-1 -: flh_pkg::TAG_W];
    endfunction

    // A disabled exchange id is replaced by zeros so every exchange of a pair hashes alike.
    function automatic logic [KW-1:0] entry_key(input logic [EW-1:0] entry, input logic use_oxid);
        logic [flh_pkg::OXID_W-1:0] xid;
        xid = use_oxid ? entry[flh_pkg::OXID_W-1:0] : '0;
        return {entry[KW-1:flh_pkg::OXID_W], xid};
    endfunction

    function automatic logic [LW:0] group_count(input logic is_fab, input logic [LW:0] fab_cnt,
                                                input logic [LW:0] eth_cnt);
        return is_fab ? fab_cnt : eth_cnt;
    endfunction

    // Config straps are synchronised since they come from a slow management domain.
    logic [1:0] fab_sync_reg, fab_sync_next;
    logic [1:0] eth_sync_reg, eth_sync_next;
    logic oxid_fab_reg, oxid_fab_next;
    logic oxid_eth_reg, oxid_eth_next;

    always_comb
    begin
        fab_sync_next = {fab_sync_reg[0], oxid_en_fabric};
        eth_sync_next = {eth_sync_reg[0], oxid_en_ethernet};
        // Only the second stage is read, so a metastable first stage never reaches the key.
        oxid_fab_next = fab_sync_reg[1];
        oxid_eth_next = eth_sync_reg[1];
    end

    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            fab_sync_reg <= {2{flh_pkg::OXID_EN_RESET}};
            eth_sync_reg <= {2{flh_pkg::OXID_EN_RESET}};
            oxid_fab_reg <= flh_pkg::OXID_EN_RESET;
            oxid_eth_reg <= flh_pkg::OXID_EN_RESET;
        end
        else
        begin
            fab_sync_reg <= fab_sync_next;
            eth_sync_reg <= eth_sync_next;
            oxid_fab_reg <= oxid_fab_next;
            oxid_eth_reg <= oxid_eth_next;
        end
    end

    // Input frames are buffered so the multi-cycle selector can stall the pipeline.
    logic [EW-1:0] fifo_in, fifo_out;
    logic fifo_valid, fifo_ready;

    assign fifo_in = {in_tag, in_is_fabric, in_source_id, in_destination_id, in_fabric_identifier,
                      in_ingress_port_number, in_ingress_module_number, in_exchange_id};

    flh_fifo #(
        .WIDTH(EW),
        .DEPTH(flh_pkg::FIFO_DEPTH),
        .AW(flh_pkg::FIFO_AW)
    ) u_fifo (
        .mclk(mclk),
        .rst(rst),
        .in_valid(in_valid),
        .in_ready(in_ready),
        .in_data(fifo_in),
        .out_valid(fifo_valid),
        .out_ready(fifo_ready),
        .out_data(fifo_out)
    );

    flh_pkg::flh_state_e state_reg, state_next;
    logic [flh_pkg::TAG_W-1:0] tag_reg, tag_next;
    logic [KW-1:0] key_reg, key_next;
    logic head_fab;
    logic [HW-1:0] hash_reg, hash_next;
    logic [HW-1:0] rem_reg, rem_next;
    logic [LW:0] cnt_reg, cnt_next;
    logic [LW-1:0] link_reg, link_next;
    logic drop_reg, drop_next;
    logic oxid_use;

    always_comb
    begin
        state_next = state_reg;
        tag_next = tag_reg;
        key_next = key_reg;
        hash_next = hash_reg;
        rem_next = rem_reg;
        cnt_next = cnt_reg;
        link_next = link_reg;
        drop_next = drop_reg;
        fifo_ready = 1'b0;
        head_fab = entry_is_fabric(fifo_out);
        oxid_use = head_fab ? oxid_fab_reg : oxid_eth_reg;
        case (state_reg)
            flh_pkg::FLH_IDLE:
            begin
                fifo_ready = 1'b1;
                if (fifo_valid)
                begin
                    tag_next = entry_tag(fifo_out);
                    // The five fixed fields always enter; the exchange id is zeroed when disabled.
                    key_next = entry_key(fifo_out, oxid_use);
                    cnt_next = group_count(head_fab, fabric_active_count, ethernet_active_count);
                    state_next = flh_pkg::FLH_HASH;
                end
            end
            flh_pkg::FLH_HASH:
            begin
                hash_next = key_hash(key_reg);
                rem_next = key_hash(key_reg);
                state_next = flh_pkg::FLH_MOD;
            end
            flh_pkg::FLH_MOD:
            begin
                // Repeated subtraction keeps the divider small at the cost of latency.
                if (cnt_reg == '0)
                begin
                    drop_next = 1'b1;
                    link_next = '0;
                    state_next = flh_pkg::FLH_OUT;
                end
                else if (rem_reg >= HW'(cnt_reg))
                begin
                    rem_next = rem_reg - HW'(cnt_reg);
                end
                else
                begin
                    drop_next = 1'b0;
                    link_next = rem_reg[LW-1:0];
                    state_next = flh_pkg::FLH_OUT;
                end
            end
            flh_pkg::FLH_OUT:
            begin
                if (out_ready)
                begin
                    state_next = flh_pkg::FLH_IDLE;
                end
            end
            default:
            begin
                state_next = flh_pkg::FLH_IDLE;
            end
        endcase
    end

    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            state_reg <= flh_pkg::FLH_IDLE;
            tag_reg <= '0;
            key_reg <= '0;
            hash_reg <= '0;
            rem_reg <= '0;
            cnt_reg <= '0;
            link_reg <= '0;
            drop_reg <= 1'b0;
        end
        else
        begin
            state_reg <= state_next;
            tag_reg <= tag_next;
            key_reg <= key_next;
            hash_reg <= hash_next;
            rem_reg <= rem_next;
            cnt_reg <= cnt_next;
            link_reg <= link_next;
            drop_reg <= drop_next;
        end
    end

    assign out_valid = (state_reg == flh_pkg::FLH_OUT);
    assign out_tag = tag_reg;
    assign out_link = link_reg;
    assign out_hash = hash_reg;
    assign out_drop = drop_reg;
endmodule
`default_nettype wire

// *** test/flh_select_properties.sv ***
// Checker for the FCoE aggregated-link selector outputs.
`timescale 1ns/1ps
`default_nettype none
module flh_select_chk (
    input wire logic mclk,
    input wire logic rst,
    input wire logic [flh_pkg::LINK_W:0] fabric_active_count,
    input wire logic [flh_pkg::LINK_W:0] ethernet_active_count,
    input wire logic in_ready,
    input wire logic out_valid,
    input wire logic out_ready,
    input wire logic [flh_pkg::TAG_W-1:0] out_tag,
    input wire logic [flh_pkg::LINK_W-1:0] out_link,
    input wire logic [flh_pkg::HASH_W-1:0] out_hash,
    input wire logic out_drop
);
    default clocking @(posedge mclk); endclocking
    default disable iff (rst);
    sequence s_wait; out_valid && !out_ready; endsequence
    sequence s_hand; out_valid && out_ready; endsequence
    sequence s_idle; !out_valid [*2]; endsequence
    property p_hold_valid; s_wait |=> out_valid; endproperty
    a_hold_valid: assert property (p_hold_valid) else $error("valid dropped early");
    property p_hold_data; s_wait |=> $stable({out_tag, out_link, out_hash, out_drop}); endproperty
    a_hold_data: assert property (p_hold_data) else $error("result changed early");
    property p_gap; s_hand |=> s_idle; endproperty
    a_gap: assert property (p_gap) else $error("result repeated");
    property p_mod; out_valid && !out_drop && fabric_active_count == ethernet_active_count
        |-> out_link == out_hash % fabric_active_count; endproperty
    a_mod: assert property (p_mod) else $error("link not hash modulo count");
    property p_zero; out_valid && fabric_active_count == 0 && ethernet_active_count == 0 |-> out_drop; endproperty
    a_zero: assert property (p_zero) else $error("no drop at zero count");
    property p_live; out_valid && fabric_active_count == ethernet_active_count && fabric_active_count != 0
        |-> !out_drop; endproperty
    a_live: assert property (p_live) else $error("drop with live links");
    property p_drop_link; out_valid && out_drop |-> out_link == 0; endproperty
    a_drop_link: assert property (p_drop_link) else $error("drop with link set");
    property p_ready_rel; $fell(rst) |-> in_ready; endproperty
    a_ready_rel: assert property (p_ready_rel) else $error("not ready after reset");
endmodule
bind flh_select flh_select_chk flh_select_chk_inst (
    .mclk(mclk),
    .rst(rst),
    .fabric_active_count(fabric_active_count),
    .ethernet_active_count(ethernet_active_count),
    .in_ready(in_ready),
    .out_valid(out_valid),
    .out_ready(out_ready),
    .out_tag(out_tag),
    .out_link(out_link),
    .out_hash(out_hash),
    .out_drop(out_drop)
);
`default_nettype wire

// *** test/flh_link_sink.sv ***
// Far-side link model that takes results promptly, slowly or not at all.
`timescale 1ns/1ps
`default_nettype none
module flh_link_sink (
    input wire logic mclk,
    input wire logic rst,
    input wire logic stall,
    input wire logic slow,
    output logic out_ready
);
    logic [1:0] cnt_reg;
    always_ff @(posedge mclk)
    begin
        cnt_reg <= rst ? 2'h0 : cnt_reg + 2'h1;
        out_ready <= !rst && !stall && (!slow || cnt_reg == 2'h3);
    end
endmodule
`default_nettype wire

// *** test/fcoe_lag_link_hash_select_test.sv ***
// Self-checking bench for the FCoE aggregated-link selector.
`timescale 1ns/1ps
`default_nettype none
module fcoe_lag_link_hash_select_test;
    logic mclk = 0, rst = 1, oxid_en_fabric = 1, oxid_en_ethernet = 1, in_valid = 0, in_is_fabric = 0;
    logic stall = 0, slow = 0, in_ready, out_valid, out_ready, out_drop;
    logic [4:0] fabric_active_count = 5'h10, ethernet_active_count = 5'h10;
    logic [15:0] in_tag = 0, in_exchange_id = 0, out_tag, out_hash;
    logic [23:0] in_source_id = 24'h010203, in_destination_id = 24'h0A0B0C;
    logic [11:0] in_fabric_identifier = 12'h123;
    logic [7:0] in_ingress_port_number = 8'h05, in_ingress_module_number = 8'h02;
    logic [3:0] out_link;
    logic [36:0] q[$];
    int error_cnt = 0, cmp_count = 0;
    flh_select flh_select_inst (
        .mclk(mclk),
        .rst(rst),
        .oxid_en_fabric(oxid_en_fabric),
        .oxid_en_ethernet(oxid_en_ethernet),
        .fabric_active_count(fabric_active_count),
        .ethernet_active_count(ethernet_active_count),
        .in_valid(in_valid),
        .in_ready(in_ready),
        .in_tag(in_tag),
        .in_is_fabric(in_is_fabric),
        .in_source_id(in_source_id),
        .in_destination_id(in_destination_id),
        .in_fabric_identifier(in_fabric_identifier),
        .in_ingress_port_number(in_ingress_port_number),
        .in_ingress_module_number(in_ingress_module_number),
        .in_exchange_id(in_exchange_id),
        .out_valid(out_valid),
        .out_ready(out_ready),
        .out_tag(out_tag),
        .out_link(out_link),
        .out_hash(out_hash),
        .out_drop(out_drop)
    );
    flh_link_sink flh_link_sink_inst (.mclk(mclk), .rst(rst), .stall(stall), .slow(slow), .out_ready(out_ready));
    initial forever #2 mclk = ~mclk;
    always @(posedge mclk)
        if (out_valid === 1'b1 && out_ready === 1'b1)
            q.push_back({out_tag, out_link, out_hash, out_drop});
    function automatic logic [15:0] crc(input logic inc);
        logic [flh_pkg::KEY_W-1:0] k;
        logic [15:0] c;
        k = {in_source_id, in_destination_id, in_fabric_identifier, in_ingress_port_number,
            in_ingress_module_number, inc ? in_exchange_id : 16'h0000};
        c = flh_pkg::HASH_SEED;
        for (int i = flh_pkg::KEY_W - 1; i >= 0; i--)
            c = {c[14:0], 1'b0} ^ ((c[15] ^ k[i]) ? flh_pkg::HASH_POLY : 16'h0000);
        return c;
    endfunction
    task automatic check(input logic [36:0] got, input logic [36:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("mismatch at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    task automatic wait_out(input int n);
        for (int i = 0; i < 20000 && q.size() < n; i++) @(posedge mclk);
        check(37'(q.size() >= n), 37'h1);
    endtask
    task automatic xfer(input logic [15:0] t, input logic f, input logic inc, input logic [4:0] n);
        logic [15:0] h;
        in_tag <= t;
        in_is_fabric <= f;
        in_valid <= 1'b1;
        @(posedge mclk);
        while (in_ready !== 1'b1) @(posedge mclk);
        in_valid <= 1'b0;
        h = crc(inc);
        wait_out(1);
        check(q.pop_front(), {t, 4'(h % n), h, 1'b0});
    endtask
    task automatic t_default;
        in_exchange_id <= 16'h1234;
        xfer(16'h0001, 1'b0, 1'b1, 5'h10);
        in_exchange_id <= 16'hABCD;
        slow <= 1'b1;
        xfer(16'h0002, 1'b0, 1'b1, 5'h10);
        xfer(16'h0003, 1'b1, 1'b1, 5'h10);
        slow <= 1'b0;
        $display("test default done");
    endtask
    task automatic t_oxid;
        fabric_active_count <= 5'h0F;
        ethernet_active_count <= 5'h0F;
        oxid_en_ethernet <= 1'b0;
        in_source_id <= 24'h0F0000;
        repeat (5) @(posedge mclk);
        xfer(16'h0011, 1'b0, 1'b0, 5'h0F);
        in_exchange_id <= 16'h1234;
        xfer(16'h0012, 1'b0, 1'b0, 5'h0F);
        xfer(16'h0013, 1'b1, 1'b1, 5'h0F);
        oxid_en_fabric <= 1'b0;
        oxid_en_ethernet <= 1'b1;
        fabric_active_count <= 5'h07;
        repeat (5) @(posedge mclk);
        xfer(16'h0014, 1'b1, 1'b0, 5'h07);
        xfer(16'h0015, 1'b0, 1'b1, 5'h0F);
        $display("test oxid done");
    endtask
    task automatic t_fill;
        int n;
        logic [36:0] r;
        n = 0;
        fabric_active_count <= 5'h00;
        ethernet_active_count <= 5'h00;
        stall <= 1'b1;
        in_tag <= 16'h0000;
        in_valid <= 1'b1;
        repeat (40)
        begin
            @(posedge mclk);
            if (in_ready === 1'b1) n++;
            in_tag <= 16'(n);
        end
        check(37'(n >= 32 && n <= 34), 37'h1);
        in_valid <= 1'b0;
        stall <= 1'b0;
        wait_out(n);
        for (int i = 0; i < n; i++)
        begin
            r = q.pop_front();
            check({r[36:17], r[0]}, {16'(i), 4'h0, 1'b1});
        end
        $display("test fill done");
    endtask
    task automatic print_verdict;
        $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    initial
    begin
        repeat (4) @(posedge mclk);
        rst <= 1'b0;
        t_default;
        t_oxid;
        t_fill;
        print_verdict;
    end
    initial
    begin
        repeat (90000) @(posedge mclk);
        error_cnt++;
        print_verdict;
    end
endmodule
`default_nettype wire
